// [crxof_engine.sv]
// protocol engine model delivering received frames to the block
`timescale 1ns/100ps

module crxof_engine (
    input wire logic core_clk,
    output logic frame_valid,
    output crxof_pkg::crxof_frame_t frame
);
    initial begin
        frame_valid = 1'b0;
        frame = '0;
    end

    // one-cycle pulse, frame held with it; inverted junk outside the pulse
    task automatic send(input crxof_pkg::crxof_frame_t f);
        @(posedge core_clk);
        #2;
        frame_valid = 1'b1;
        frame = f;
        @(posedge core_clk);
        #2;
        frame_valid = 1'b0;
        frame = ~f;
    endtask
endmodule

// [crxof_pkg.sv]
// constants and carrier types for the receive filter and overflow block
package crxof_pkg;
    localparam int NRULE = 4;
    localparam int NBUF = 4;
    localparam int TXQ_MAX = 8;
    localparam int RXFIFO_DEPTH = 16;
    localparam int RXFIFO_CW = 5;
    localparam int BUF_IW = 2;
    localparam int TXQ_PW = 3;
    localparam int TXQ_CW = 4;
    localparam int RULE_IW = 2;
    localparam logic [TXQ_CW-1:0] TXQ_CNT_RST = 4'h0;
    localparam logic [TXQ_PW-1:0] TXQ_PTR_RST = 3'h0;
    localparam logic [NBUF-1:0] BUF_NEW_RST = 4'h0;
    localparam logic [TXQ_CW-1:0] TXQ_DEPTH_BASE = 4'h1;

    typedef enum logic [1:0] {
        CRXOF_DEST_RXBUF = 2'h0,
        CRXOF_DEST_RXFIFO = 2'h1,
        CRXOF_DEST_TXQ = 2'h2,
        CRXOF_DEST_NONE = 2'h3
    } crxof_dest_t;

    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic own_tx;
        logic [3:0] dlc;
        logic [63:0] data;
    } crxof_frame_t;

    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic [3:0] dlc;
        logic [15:0] label;
        logic [63:0] data;
    } crxof_msg_t;

    typedef struct packed {
        logic [28:0] id;
        logic [28:0] id_mask;
        logic ide;
        logic ide_mask;
        logic rtr;
        logic rtr_mask;
        logic own_tx;
        logic [3:0] dlc;
        logic [15:0] label;
        crxof_dest_t dest;
        logic [BUF_IW-1:0] buf_idx;
    } crxof_rule_t;
endpackage

// [crxof_top.sv]
// receive rule filter, receive buffers, receive fifo and rx-mode tx/rx fifo
//
// Contract
// (R01) rxbuf hit on unread message overwrites it
// (R02) rxbuf overwrite pulses payload overwrite error
// (R03) full receive fifo drops the new frame
// (R04) receive fifo drop pulses message lost error
// (R05) full txq, overwrite mode 1: replace oldest
// (R06) txq oldest overwrite pulses overwrite error
// (R07) full txq, overwrite mode 0: drop, lost
// (R08) match id, ide, rtr under rule masks
// (R09) mirror on: rule selects own or foreign
// (R10) dlc check on: frame dlc against rule
// (R11) check and replace on: store rule dlc
// (R12) store to rule destination with rule label
// (R13) txq full at count=depth, empty at zero
// (R14) overflow decision from fill state at store
`timescale 1ns/100ps

module crxof_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int CW = 5
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr, rd, next_wr, next_rd;
    logic [CW-1:0] next_count;
    logic push, pop;

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr = push ? PW'(wr + 1'b1) : wr;
        next_rd = pop ? PW'(rd + 1'b1) : rd;
        next_count = CW'(count + CW'(push) - CW'(pop));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr <= '0;
            rd <= '0;
            count <= '0;
        end else begin
            wr <= next_wr;
            rd <= next_rd;
            count <= next_count;
        end
        if (push) begin
            mem[wr] <= in_data;
        end
    end
endmodule

module crxof_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic frame_valid,
    input wire crxof_pkg::crxof_frame_t frame,
    input wire crxof_pkg::crxof_rule_t [crxof_pkg::NRULE-1:0] rules,
    input wire logic mirror_en,
    input wire logic dlc_check_en,
    input wire logic dlc_replace_en,
    input wire logic fifo_overwrite_mode,
    input wire logic [2:0] fifo_depth_sel,
    input wire logic [crxof_pkg::BUF_IW-1:0] rxbuf_sel,
    input wire logic [crxof_pkg::NBUF-1:0] rxbuf_clear,
    output logic [crxof_pkg::NBUF-1:0] rxbuf_new,
    output crxof_pkg::crxof_msg_t rxbuf_msg,
    output logic rxfifo_valid,
    input wire logic rxfifo_ready,
    output crxof_pkg::crxof_msg_t rxfifo_msg,
    output logic [crxof_pkg::RXFIFO_CW-1:0] rxfifo_count,
    input wire logic txq_pop,
    output crxof_pkg::crxof_msg_t txq_msg,
    output logic txq_full,
    output logic txq_empty,
    output logic [crxof_pkg::TXQ_CW-1:0] fifo_msg_count,
    output logic err_payload_overwrite,
    output logic err_rxfifo_lost,
    output logic err_txq_overwrite,
    output logic err_txq_lost
);
    logic [crxof_pkg::NRULE-1:0] rule_hit;
    logic any_hit;
    logic [crxof_pkg::RULE_IW-1:0] hit_idx;
    crxof_pkg::crxof_rule_t hit_rule;
    crxof_pkg::crxof_msg_t msg;
    logic to_buf, to_fifo, to_txq, fifo_in_ready;

    // acceptance filter per rule
    for (genvar g = 0; g < crxof_pkg::NRULE; g++) begin : g_rule
        assign rule_hit[g] =
            (((frame.id ^ rules[g].id) & rules[g].id_mask) == '0) && // [R08]
            (((frame.ide ^ rules[g].ide) & rules[g].ide_mask) == 1'b0) &&
            (((frame.rtr ^ rules[g].rtr) & rules[g].rtr_mask) == 1'b0) &&
            (!mirror_en || (frame.own_tx == rules[g].own_tx)) && // [R09]
            (!dlc_check_en || (frame.dlc >= rules[g].dlc)); // [R10]
    end

    // lowest numbered matching rule wins
    always_comb begin
        hit_idx = '0;
        for (int i = crxof_pkg::NRULE - 1; i >= 0; i--) begin
            if (rule_hit[i]) begin
                hit_idx = crxof_pkg::RULE_IW'(i);
            end
        end
        any_hit = frame_valid && (rule_hit != '0);
        hit_rule = rules[hit_idx];
        msg.id = frame.id;
        msg.ide = frame.ide;
        msg.rtr = frame.rtr;
        msg.data = frame.data;
        msg.label = hit_rule.label; // [R12]
        msg.dlc = (dlc_check_en && dlc_replace_en) ? hit_rule.dlc
                                                   : frame.dlc; // [R11]
        to_buf = any_hit && (hit_rule.dest == crxof_pkg::CRXOF_DEST_RXBUF);
        to_fifo = any_hit && (hit_rule.dest == crxof_pkg::CRXOF_DEST_RXFIFO);
        to_txq = any_hit && (hit_rule.dest == crxof_pkg::CRXOF_DEST_TXQ);
    end

    // receive fifo, refuses when full
    crxof_fifo #(
        .W($bits(crxof_pkg::crxof_msg_t)),
        .DEPTH(crxof_pkg::RXFIFO_DEPTH),
        .CW(crxof_pkg::RXFIFO_CW)
    ) u_rxfifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(to_fifo), // [R12]
        .in_ready(fifo_in_ready), // [R03]
        .in_data(msg),
        .out_valid(rxfifo_valid),
        .out_ready(rxfifo_ready),
        .out_data(rxfifo_msg),
        .count(rxfifo_count)
    );

    // receive buffers
    crxof_pkg::crxof_msg_t rxbuf [crxof_pkg::NBUF];
    crxof_pkg::crxof_msg_t next_rxbuf [crxof_pkg::NBUF];
    logic [crxof_pkg::NBUF-1:0] next_rxbuf_new;
    crxof_pkg::crxof_msg_t next_rxbuf_msg;
    logic next_err_payload_overwrite;
    logic next_err_rxfifo_lost;

    always_comb begin
        next_rxbuf = rxbuf;
        next_rxbuf_new = rxbuf_new & ~rxbuf_clear;
        next_err_payload_overwrite = 1'b0;
        next_err_rxfifo_lost = to_fifo && !fifo_in_ready; // [R04]
        if (to_buf) begin
            next_rxbuf[hit_rule.buf_idx] = msg; // [R01] [R12]
            next_rxbuf_new[hit_rule.buf_idx] = 1'b1;
            next_err_payload_overwrite = rxbuf_new[hit_rule.buf_idx]; // [R02]
        end
        next_rxbuf_msg = rxbuf[rxbuf_sel];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxbuf_new <= crxof_pkg::BUF_NEW_RST;
            err_payload_overwrite <= 1'b0;
            err_rxfifo_lost <= 1'b0;
        end else begin
            rxbuf_new <= next_rxbuf_new;
            err_payload_overwrite <= next_err_payload_overwrite;
            err_rxfifo_lost <= next_err_rxfifo_lost;
        end
        rxbuf <= next_rxbuf;
        rxbuf_msg <= next_rxbuf_msg;
    end

    // tx/rx fifo in receive mode, depth set by fifo_depth_sel
    crxof_pkg::crxof_msg_t txq_mem [crxof_pkg::TXQ_MAX];
    logic [crxof_pkg::TXQ_PW-1:0] txq_wr, txq_rd, next_txq_wr, next_txq_rd;
    logic [crxof_pkg::TXQ_CW-1:0] next_count, txq_depth;
    logic txq_pop_ok, txq_room, txq_store;
    logic next_err_txq_overwrite, next_err_txq_lost;

    function automatic logic [crxof_pkg::TXQ_PW-1:0] txq_inc(
        input logic [crxof_pkg::TXQ_PW-1:0] p,
        input logic [crxof_pkg::TXQ_CW-1:0] d
    );
        txq_inc = (p == crxof_pkg::TXQ_PW'(d - 4'h1)) ? '0
                  : crxof_pkg::TXQ_PW'(p + 1'b1);
    endfunction

    assign txq_depth = {1'b0, fifo_depth_sel} + crxof_pkg::TXQ_DEPTH_BASE;
    assign txq_full = (fifo_msg_count == txq_depth); // [R13]
    assign txq_empty = (fifo_msg_count == crxof_pkg::TXQ_CNT_RST); // [R13]
    assign txq_msg = txq_mem[txq_rd];

    always_comb begin
        txq_pop_ok = txq_pop && !txq_empty;
        txq_room = !txq_full || txq_pop_ok; // [R14]
        txq_store = 1'b0;
        next_txq_wr = txq_wr;
        next_txq_rd = txq_pop_ok ? txq_inc(txq_rd, txq_depth) : txq_rd;
        next_count = fifo_msg_count - crxof_pkg::TXQ_CW'(txq_pop_ok);
        next_err_txq_overwrite = 1'b0;
        next_err_txq_lost = 1'b0;
        if (to_txq) begin
            if (txq_room) begin
                txq_store = 1'b1;
                next_txq_wr = txq_inc(txq_wr, txq_depth);
                next_count = crxof_pkg::TXQ_CW'(next_count + 4'h1);
            end else if (fifo_overwrite_mode) begin
                txq_store = 1'b1; // [R05]
                next_txq_wr = txq_inc(txq_wr, txq_depth);
                next_txq_rd = txq_inc(txq_rd, txq_depth);
                next_err_txq_overwrite = 1'b1; // [R06]
            end else begin
                next_err_txq_lost = 1'b1; // [R07]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txq_wr <= crxof_pkg::TXQ_PTR_RST;
            txq_rd <= crxof_pkg::TXQ_PTR_RST;
            fifo_msg_count <= crxof_pkg::TXQ_CNT_RST;
            err_txq_overwrite <= 1'b0;
            err_txq_lost <= 1'b0;
        end else begin
            txq_wr <= next_txq_wr;
            txq_rd <= next_txq_rd;
            fifo_msg_count <= next_count;
            err_txq_overwrite <= next_err_txq_overwrite;
            err_txq_lost <= next_err_txq_lost;
        end
        if (txq_store) begin
            txq_mem[txq_wr] <= msg;
        end
    end

    // checks
    sequence s_buf_hit_unread;
        to_buf && rxbuf_new[hit_rule.buf_idx];
    endsequence

    sequence s_txq_full_ovw;
        to_txq && txq_full && !txq_pop && fifo_overwrite_mode;
    endsequence

    sequence s_txq_full_drop;
        to_txq && txq_full && !txq_pop && !fifo_overwrite_mode;
    endsequence

    property p_buf_store;
        @(posedge core_clk) disable iff (rst)
        to_buf |=> rxbuf_new[$past(hit_rule.buf_idx)]
            && rxbuf[$past(hit_rule.buf_idx)] == $past(msg);
    endproperty
    a_buf_store: assert property (p_buf_store) // [R01]
        else $error("rx buffer not written with frame");

    property p_buf_ovw;
        @(posedge core_clk) disable iff (rst)
        s_buf_hit_unread |=> err_payload_overwrite;
    endproperty
    a_buf_ovw: assert property (p_buf_ovw) // [R02]
        else $error("payload overwrite not flagged");

    property p_fifo_lost;
        @(posedge core_clk) disable iff (rst)
        (to_fifo && !fifo_in_ready && !rxfifo_ready)
            |=> err_rxfifo_lost && $stable(rxfifo_count);
    endproperty
    a_fifo_lost: assert property (p_fifo_lost) // [R03] [R04]
        else $error("full receive fifo did not drop and flag");

    property p_txq_ovw;
        @(posedge core_clk) disable iff (rst)
        s_txq_full_ovw
            |=> err_txq_overwrite && $stable(fifo_msg_count)
                && (txq_rd != $past(txq_rd)
                    || txq_depth == crxof_pkg::TXQ_DEPTH_BASE);
    endproperty
    a_txq_ovw: assert property (p_txq_ovw) // [R05] [R06]
        else $error("txq oldest overwrite wrong");

    property p_txq_lost;
        @(posedge core_clk) disable iff (rst)
        s_txq_full_drop
            |=> err_txq_lost && !err_txq_overwrite && $stable(txq_wr);
    endproperty
    a_txq_lost: assert property (p_txq_lost) // [R07]
        else $error("txq drop not flagged");

    property p_no_hit;
        @(posedge core_clk) disable iff (rst)
        (frame_valid && rule_hit == '0 && !txq_pop && !rxfifo_ready)
            |=> $stable(rxfifo_count) && $stable(fifo_msg_count)
                && !err_payload_overwrite;
    endproperty
    a_no_hit: assert property (p_no_hit) // [R08]
        else $error("unmatched frame was stored");

    property p_dlc_repl;
        @(posedge core_clk) disable iff (rst)
        (to_buf && dlc_check_en && dlc_replace_en)
            |=> rxbuf[$past(hit_rule.buf_idx)].dlc == $past(hit_rule.dlc)
                && rxbuf[$past(hit_rule.buf_idx)].label
                   == $past(hit_rule.label);
    endproperty
    a_dlc_repl: assert property (p_dlc_repl) // [R11] [R12]
        else $error("stored dlc or label wrong");

    property p_txq_fill;
        @(posedge core_clk) disable iff (rst)
        (to_txq && !txq_pop && fifo_msg_count == txq_depth - 4'h1)
            |=> txq_full ##1 (!txq_empty || ($past(txq_pop)
                && txq_depth == crxof_pkg::TXQ_DEPTH_BASE));
    endproperty
    a_txq_fill: assert property (p_txq_fill) // [R13] [R14]
        else $error("txq full flag wrong");
endmodule

// [tb.sv]
// self-checking testbench for the receive filter and overflow block
`timescale 1ns/100ps

module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic frame_valid;
    crxof_pkg::crxof_frame_t frame;
    crxof_pkg::crxof_rule_t [crxof_pkg::NRULE-1:0] rules = '0;
    logic mirror_en = 1'b0;
    logic dlc_check_en = 1'b0;
    logic dlc_replace_en = 1'b0;
    logic fifo_overwrite_mode = 1'b0;
    logic [2:0] fifo_depth_sel = 3'h1;
    logic [1:0] rxbuf_sel = 2'h2;
    logic [3:0] rxbuf_clear = 4'h0;
    logic rxfifo_ready = 1'b0;
    logic txq_pop = 1'b0;
    logic [3:0] rxbuf_new;
    crxof_pkg::crxof_msg_t rxbuf_msg, rxfifo_msg, txq_msg;
    logic rxfifo_valid, txq_full, txq_empty;
    logic [4:0] rxfifo_count;
    logic [3:0] fifo_msg_count;
    logic err_payload_overwrite, err_rxfifo_lost;
    logic err_txq_overwrite, err_txq_lost;
    int failures = 0;
    int n_tests = 0;

    always #10 core_clk = ~core_clk;

    crxof_engine u_eng (.core_clk(core_clk), .frame_valid(frame_valid),
        .frame(frame));

    crxof_top u_dut (.core_clk(core_clk), .rst(rst),
        .frame_valid(frame_valid), .frame(frame), .rules(rules),
        .mirror_en(mirror_en), .dlc_check_en(dlc_check_en),
        .dlc_replace_en(dlc_replace_en),
        .fifo_overwrite_mode(fifo_overwrite_mode),
        .fifo_depth_sel(fifo_depth_sel), .rxbuf_sel(rxbuf_sel),
        .rxbuf_clear(rxbuf_clear), .rxbuf_new(rxbuf_new),
        .rxbuf_msg(rxbuf_msg), .rxfifo_valid(rxfifo_valid),
        .rxfifo_ready(rxfifo_ready), .rxfifo_msg(rxfifo_msg),
        .rxfifo_count(rxfifo_count), .txq_pop(txq_pop), .txq_msg(txq_msg),
        .txq_full(txq_full), .txq_empty(txq_empty),
        .fifo_msg_count(fifo_msg_count),
        .err_payload_overwrite(err_payload_overwrite),
        .err_rxfifo_lost(err_rxfifo_lost),
        .err_txq_overwrite(err_txq_overwrite), .err_txq_lost(err_txq_lost));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic crxof_pkg::crxof_frame_t mkf(input logic [28:0] id,
        input logic [3:0] dlc, input logic [63:0] d, input logic own);
        mkf = '0;
        mkf.id = id;
        mkf.dlc = dlc;
        mkf.data = d;
        mkf.own_tx = own;
    endfunction

    function automatic crxof_pkg::crxof_rule_t mkr(input logic [28:0] id,
        input logic [28:0] m, input crxof_pkg::crxof_dest_t d,
        input logic [1:0] b, input logic [15:0] lbl, input logic own);
        mkr = '0;
        mkr.id = id;
        mkr.id_mask = m;
        mkr.ide_mask = 1'b1;
        mkr.rtr_mask = 1'b1;
        mkr.dest = d;
        mkr.buf_idx = b;
        mkr.label = lbl;
        mkr.own_tx = own;
        mkr.dlc = 4'h8;
    endfunction

    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask

    task automatic clr(input logic [3:0] m);
        tick();
        rxbuf_clear = m;
        tick();
        rxbuf_clear = 4'h0;
    endtask

    task automatic pop_tx();
        txq_pop = 1'b1;
        tick();
        txq_pop = 1'b0;
    endtask

    task automatic t_rxbuf();
        u_eng.send(mkf(29'h100, 4'h8, 64'h11, 1'b0));
        chk(rxbuf_new, 4'h4);
        chk(err_payload_overwrite, 1'b0);
        u_eng.send(mkf(29'h100, 4'h8, 64'h22, 1'b0));
        chk(err_payload_overwrite, 1'b1);
        tick();
        chk(rxbuf_msg.data, 64'h22);
        chk(rxbuf_msg.label, 16'hA5A5);
        clr(4'h4);
        chk(rxbuf_new, 4'h0);
        u_eng.send(mkf(29'h100, 4'h8, 64'h33, 1'b0));
        chk(err_payload_overwrite, 1'b0);
    endtask

    task automatic t_rxfifo();
        for (int i = 0; i < 16; i++) begin
            u_eng.send(mkf(29'h200, 4'h8, 64'(i), 1'b0));
        end
        chk(rxfifo_count, 5'h10);
        u_eng.send(mkf(29'h200, 4'h8, 64'h99, 1'b0));
        chk(err_rxfifo_lost, 1'b1);
        chk(rxfifo_count, 5'h10);
        chk(rxfifo_msg.label, 16'h0001);
        rxfifo_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chk(rxfifo_msg.data, 64'(i));
            tick();
        end
        rxfifo_ready = 1'b0;
        chk(rxfifo_valid, 1'b0);
    endtask

    task automatic t_txq(input logic mode);
        fifo_overwrite_mode = mode;
        u_eng.send(mkf(29'h300, 4'h8, 64'h1, 1'b0));
        u_eng.send(mkf(29'h300, 4'h8, 64'h2, 1'b0));
        chk(txq_full, 1'b1);
        chk(fifo_msg_count, 4'h2);
        if (!mode) begin
            fork
                u_eng.send(mkf(29'h300, 4'h8, 64'h3, 1'b0));
                begin
                    tick();
                    pop_tx();
                end
            join
            chk(err_txq_lost, 1'b0);
            chk(fifo_msg_count, 4'h2);
        end
        u_eng.send(mkf(29'h300, 4'h8, 64'h4, 1'b0));
        chk(err_txq_overwrite, mode);
        chk(err_txq_lost, !mode);
        chk(fifo_msg_count, 4'h2);
        chk(txq_msg.data, 64'h2);
        pop_tx();
        chk(txq_msg.data, mode ? 64'h4 : 64'h3);
        tick();
        pop_tx();
        chk(txq_empty, 1'b1);
    endtask

    task automatic t_filter();
        crxof_pkg::crxof_frame_t f;
        clr(4'hC);
        f = mkf(29'h10F, 4'h8, 64'h5, 1'b0);
        f.ide = 1'b1;
        u_eng.send(f);
        chk(rxbuf_new, 4'h0);
        f.ide = 1'b0;
        f.rtr = 1'b1;
        u_eng.send(f);
        chk(rxbuf_new, 4'h0);
        u_eng.send(mkf(29'h10F, 4'h8, 64'h5, 1'b0));
        chk(rxbuf_new, 4'h4);
        clr(4'h4);
        u_eng.send(mkf(29'h110, 4'h8, 64'h6, 1'b0));
        chk(rxbuf_new, 4'h0);
        mirror_en = 1'b1;
        u_eng.send(mkf(29'h400, 4'h8, 64'h7, 1'b0));
        chk(rxbuf_new, 4'h0);
        u_eng.send(mkf(29'h400, 4'h8, 64'h7, 1'b1));
        chk(rxbuf_new, 4'h8);
        clr(4'h8);
        dlc_check_en = 1'b1;
        rxbuf_sel = 2'h3;
        u_eng.send(mkf(29'h400, 4'h4, 64'h8, 1'b1));
        chk(rxbuf_new, 4'h0);
        u_eng.send(mkf(29'h400, 4'h9, 64'h8, 1'b1));
        tick();
        chk(rxbuf_msg.dlc, 4'h9);
        dlc_replace_en = 1'b1;
        u_eng.send(mkf(29'h400, 4'h9, 64'h8, 1'b1));
        tick();
        chk(rxbuf_msg.dlc, 4'h8);
        chk(rxbuf_msg.label, 16'h3C3C);
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rules[0] = mkr(29'h100, 29'h1FFFFFF0, crxof_pkg::CRXOF_DEST_RXBUF,
            2'h2, 16'hA5A5, 1'b0);
        rules[1] = mkr(29'h200, 29'h1FFFFFFF, crxof_pkg::CRXOF_DEST_RXFIFO,
            2'h0, 16'h0001, 1'b0);
        rules[2] = mkr(29'h300, 29'h1FFFFFFF, crxof_pkg::CRXOF_DEST_TXQ,
            2'h0, 16'h0002, 1'b0);
        rules[3] = mkr(29'h400, 29'h1FFFFFFF, crxof_pkg::CRXOF_DEST_RXBUF,
            2'h3, 16'h3C3C, 1'b1);
        repeat (4) @(posedge core_clk);
        #2;
        rst = 1'b0;
        chk(txq_empty, 1'b1);
        t_rxbuf();
        t_rxfifo();
        t_txq(1'b1);
        t_txq(1'b0);
        t_filter();
        final_report();
    end

    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule
